/* rtl/fsps_seq.v */
// Flash self-program sequencer: read, row erase, latch load, block program.
// Assumes a synchronous-read flash macro and a core that obeys stall and squash.
// Functional notes
// - Flash rows are 32 words of 14 bits; erase clears a whole row.
// - Erase or program into a protected segment is refused; reads still work.
// - Program data goes into hidden 14-bit latches loaded from the data pair.
// - Latch block is 32 aligned words; programming never crosses the block.
// - Flash access uses the second following cycle; that instruction is ignored.
// - Data pair keeps the read word until next read or software write.
// - Self reads ignore the code guard bit.
// - Row-erase select clears itself when the erase completes.
// - Two setup cycles after start, then stall about 2ms for erase.
// - During a stall clocks and peripherals keep running; no sleep.
// - Programming never erases; erase exists only per whole row.
// - With latch-only set, unlock and start only load one latch.
// - With latch-only clear, load the latch then program the whole block.
// - Programming writes every latch, loaded or not.
// - After programming every latch returns to 3FFF.
// - Stall on erase and on the programming pass, never on latch-only loads.
// - Start bits are set-only for software; hardware clears them at completion.
// - Program start cannot be set unless program allow is already set.
// - Write or erase needs 55h then AAh just before program start.
// - Reset during a write sets the aborted-write flag.
//
// Local design decisions: strobed register access and the register offsets.
`include "fsps_consts.vh"

module fsps_seq #(
  parameter ERASE_CYCLES = `FSPS_ERASE_CYC,
  parameter PROG_CYCLES  = `FSPS_PROG_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset,
  // Register port
  input  wire [2:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_r,
  // Configuration
  input  wire [1:0]  protect_segment_field,
  input  wire        code_guard_bit,
  // Processor core
  output reg         cpu_stall_r,
  output reg         cpu_squash_r,
  // Flash macro
  output reg  [14:0] fl_addr_r,
  output reg  [13:0] fl_wdata_r,
  output reg         fl_rd_en_r,
  output reg         fl_wr_en_r,
  output reg         fl_erase_r,
  input  wire [13:0] fl_rdata
);

  localparam [8:0] S_IDLE  = 9'h001;
  localparam [8:0] S_RD1   = 9'h002;
  localparam [8:0] S_RD2   = 9'h004;
  localparam [8:0] S_RD3   = 9'h008;
  localparam [8:0] S_SU1   = 9'h010;
  localparam [8:0] S_SU2   = 9'h020;
  localparam [8:0] S_ERASE = 9'h040;
  localparam [8:0] S_PROG  = 9'h080;
  localparam [8:0] S_WAIT  = 9'h100;

  localparam [1:0] UNL_IDLE = 2'h0;
  localparam [1:0] UNL_KEY1 = 2'h1;
  localparam [1:0] UNL_ARM  = 2'h2;

  localparam [19:0] ERASE_WAIT = ERASE_CYCLES[19:0];
  localparam [19:0] PROG_WAIT  = PROG_CYCLES[19:0];

  // Registers
  reg [8:0]  state_r;
  reg [7:0]  addr_lo_r;
  reg [6:0]  addr_hi_r;
  reg [7:0]  data_lo_r;
  reg [5:0]  data_hi_r;
  reg        read_start_r;
  reg        prog_start_r;
  reg        allow_r;
  reg        aborted_r;
  reg        row_erase_r;
  reg        latch_only_r;
  reg        cfg_sel_r;
  reg        prog_sel_r;
  reg [1:0]  unlock_r;
  reg        busy_r;
  reg        is_erase_r;
  reg [4:0]  idx_r;
  reg [19:0] wait_r;

  // Latch bank hookup
  reg        lat_load;
  reg        lat_wipe;
  wire [13:0] lat_q;

  wire [14:0] word_addr = {addr_hi_r, addr_lo_r};
  wire        wr_ctrl   = reg_wr && (reg_addr == `FSPS_OFS_CTRL);
  wire        wr_unlock = reg_wr && (reg_addr == `FSPS_OFS_UNLOCK);
  wire        idle      = (state_r == S_IDLE);

  // Word address inside the aligned 32-word block
  function [14:0] fsps_blk_addr;
    input [14:0] a;
    input [4:0]  i;
    begin
      fsps_blk_addr = {a[14:5], i};
    end
  endfunction

  // Locked when below the segment limit; reads never ask this
  function fsps_locked;
    input [1:0]  seg;
    input [14:0] a;
    begin
      if (seg == `FSPS_SEG_NONE) begin
        fsps_locked = 1'b0;
      end else if (seg == `FSPS_SEG_LOW) begin
        fsps_locked = (a < `FSPS_LIMIT_LOW);
      end else if (seg == `FSPS_SEG_HALF) begin
        fsps_locked = (a < `FSPS_LIMIT_HALF);
      end else begin
        fsps_locked = 1'b1;
      end
    end
  endfunction

  fsps_latch_bank #(
    .WORD_W (`FSPS_WORD_W),
    .DEPTH  (`FSPS_ROW_WORDS),
    .IDX_W  (5)
  ) u_latch (
    .core_clk  (core_clk),
    .reset     (reset),
    .load      (lat_load),
    .load_idx  (addr_lo_r[4:0]),
    .load_data ({data_hi_r, data_lo_r}),
    .wipe      (lat_wipe),
    .rd_idx    (idx_r),
    .rd_data   (lat_q)
  );

  // Latch load and wipe strobes
  always @* begin
    lat_load = 1'b0;
    lat_wipe = 1'b0;
    if (state_r == S_SU2 && prog_sel_r && !cfg_sel_r && !row_erase_r &&
        !fsps_locked(protect_segment_field, word_addr)) begin
      lat_load = 1'b1;
    end
    if (state_r == S_WAIT && wait_r == 20'h00000 && !is_erase_r) begin
      lat_wipe = 1'b1;
    end
  end

  // Aborted-write flag survives reset; set wins over a software clear
  always @(posedge core_clk) begin
    if (reset) begin
      aborted_r <= aborted_r | busy_r;
    end else if (wr_ctrl && !reg_wdata[`FSPS_B_ABORTED]) begin
      aborted_r <= 1'b0;
    end
  end

  // Unlock detector
  always @(posedge core_clk) begin
    if (reset) begin
      unlock_r <= UNL_IDLE;
    end else if (wr_unlock) begin
      if (reg_wdata == `FSPS_KEY_FIRST) begin
        unlock_r <= UNL_KEY1;
      end else if (reg_wdata == `FSPS_KEY_SECOND && unlock_r == UNL_KEY1) begin
        unlock_r <= UNL_ARM;
      end else begin
        unlock_r <= UNL_IDLE;
      end
    end else if (reg_wr) begin
      unlock_r <= UNL_IDLE;
    end
  end

  // Register read port, data one cycle after the strobe
  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `FSPS_OFS_ADDR_LO) begin
        reg_rdata_r <= addr_lo_r;
      end else if (reg_addr == `FSPS_OFS_ADDR_HI) begin
        reg_rdata_r <= {1'b0, addr_hi_r};
      end else if (reg_addr == `FSPS_OFS_DATA_LO) begin
        reg_rdata_r <= data_lo_r;
      end else if (reg_addr == `FSPS_OFS_DATA_HI) begin
        reg_rdata_r <= {2'b00, data_hi_r};
      end else if (reg_addr == `FSPS_OFS_CTRL) begin
        reg_rdata_r <= {prog_sel_r, cfg_sel_r, latch_only_r, row_erase_r,
                        aborted_r, allow_r, prog_start_r, read_start_r};
      end else begin
        reg_rdata_r <= 8'h00;
      end
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  // Main sequencer
  always @(posedge core_clk) begin
    if (reset) begin
      state_r      <= S_IDLE;
      addr_lo_r    <= 8'h00;
      addr_hi_r    <= 7'h00;
      data_lo_r    <= 8'h00;
      data_hi_r    <= 6'h00;
      read_start_r <= 1'b0;
      prog_start_r <= 1'b0;
      allow_r      <= 1'b0;
      row_erase_r  <= 1'b0;
      latch_only_r <= 1'b0;
      cfg_sel_r    <= 1'b0;
      prog_sel_r   <= 1'b0;
      busy_r       <= 1'b0;
      is_erase_r   <= 1'b0;
      idx_r        <= 5'h00;
      wait_r       <= 20'h00000;
      cpu_stall_r  <= 1'b0;
      cpu_squash_r <= 1'b0;
      fl_addr_r    <= 15'h0000;
      fl_wdata_r   <= 14'h0000;
      fl_rd_en_r   <= 1'b0;
      fl_wr_en_r   <= 1'b0;
      fl_erase_r   <= 1'b0;
    end else begin
      fl_rd_en_r   <= 1'b0;
      fl_wr_en_r   <= 1'b0;
      fl_erase_r   <= 1'b0;
      cpu_squash_r <= 1'b0;
      // Software writes; address and data frozen while busy
      if (reg_wr && idle) begin
        if (reg_addr == `FSPS_OFS_ADDR_LO) begin
          addr_lo_r <= reg_wdata;
        end else if (reg_addr == `FSPS_OFS_ADDR_HI) begin
          addr_hi_r <= reg_wdata[6:0];
        end else if (reg_addr == `FSPS_OFS_DATA_LO) begin
          data_lo_r <= reg_wdata;
        end else if (reg_addr == `FSPS_OFS_DATA_HI) begin
          data_hi_r <= reg_wdata[5:0];
        end
      end
      if (wr_ctrl) begin
        allow_r <= reg_wdata[`FSPS_B_ALLOW];
        if (idle) begin
          row_erase_r  <= reg_wdata[`FSPS_B_ROW_ERASE];
          latch_only_r <= reg_wdata[`FSPS_B_LATCH_ONLY];
          cfg_sel_r    <= reg_wdata[`FSPS_B_CFG_SEL];
          prog_sel_r   <= reg_wdata[`FSPS_B_PROG_SEL];
        end
      end
      case (state_r)
        S_IDLE: begin
          // Writing 0 to a start bit has no effect
          if (wr_ctrl && reg_wdata[`FSPS_B_PROG_START] && allow_r &&
              unlock_r == UNL_ARM) begin
            prog_start_r <= 1'b1;
            is_erase_r   <= reg_wdata[`FSPS_B_ROW_ERASE];
            state_r      <= S_SU1;
          end else if (wr_ctrl && reg_wdata[`FSPS_B_READ_START]) begin
            read_start_r <= 1'b1;
            state_r      <= S_RD1;
          end
        end
        S_RD1: begin
          // First following instruction runs normally
          fl_addr_r    <= word_addr;
          fl_rd_en_r   <= prog_sel_r && !cfg_sel_r;
          cpu_squash_r <= 1'b1;
          state_r      <= S_RD2;
        end
        S_RD2: begin
          state_r <= S_RD3;
        end
        S_RD3: begin
          if (prog_sel_r && !cfg_sel_r) begin
            {data_hi_r, data_lo_r} <= fl_rdata;
          end
          read_start_r <= 1'b0;
          state_r      <= S_IDLE;
        end
        S_SU1: begin
          state_r <= S_SU2;
        end
        S_SU2: begin
          if (!prog_sel_r || cfg_sel_r ||
              fsps_locked(protect_segment_field, word_addr)) begin
            prog_start_r <= 1'b0;
            state_r      <= S_IDLE;
          end else if (is_erase_r) begin
            busy_r      <= 1'b1;
            cpu_stall_r <= 1'b1;
            state_r     <= S_ERASE;
          end else if (latch_only_r) begin
            prog_start_r <= 1'b0;
            state_r      <= S_IDLE;
          end else begin
            busy_r      <= 1'b1;
            cpu_stall_r <= 1'b1;
            idx_r       <= 5'h00;
            state_r     <= S_PROG;
          end
        end
        S_ERASE: begin
          fl_addr_r  <= fsps_blk_addr(word_addr, 5'h00);
          fl_erase_r <= 1'b1;
          wait_r     <= ERASE_WAIT - 20'h00001;
          state_r    <= S_WAIT;
        end
        S_PROG: begin
          // Every latch is written, loaded or not; no erase here
          fl_addr_r  <= fsps_blk_addr(word_addr, idx_r);
          fl_wdata_r <= lat_q;
          fl_wr_en_r <= 1'b1;
          idx_r      <= idx_r + 5'h01;
          if (idx_r == 5'h1F) begin
            wait_r  <= PROG_WAIT - 20'h00001;
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (wait_r == 20'h00000) begin
            prog_start_r <= 1'b0;
            if (is_erase_r) begin
              row_erase_r <= 1'b0;
            end
            busy_r      <= 1'b0;
            cpu_stall_r <= 1'b0;
            state_r     <= S_IDLE;
          end else begin
            wait_r <= wait_r - 20'h00001;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule // fsps_seq

/* inc/fsps_consts.vh */
// Constants for the flash self-program sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef FSPS_CONSTS_VH
`define FSPS_CONSTS_VH

// Register offsets on the plain register port
`define FSPS_OFS_ADDR_LO   3'h0
`define FSPS_OFS_ADDR_HI   3'h1
`define FSPS_OFS_DATA_LO   3'h2
`define FSPS_OFS_DATA_HI   3'h3
`define FSPS_OFS_CTRL      3'h4
`define FSPS_OFS_UNLOCK    3'h5

// Control register bit positions
`define FSPS_B_READ_START  0
`define FSPS_B_PROG_START  1
`define FSPS_B_ALLOW       2
`define FSPS_B_ABORTED     3
`define FSPS_B_ROW_ERASE   4
`define FSPS_B_LATCH_ONLY  5
`define FSPS_B_CFG_SEL     6
`define FSPS_B_PROG_SEL    7

// Unlock keys
`define FSPS_KEY_FIRST     8'h55
`define FSPS_KEY_SECOND    8'hAA

// Geometry and reset values
`define FSPS_WORD_W        14
`define FSPS_ADDR_W        15
`define FSPS_ROW_WORDS     32
`define FSPS_ERASED_WORD   14'h3FFF

// Protect segment limits: words below the limit are locked
`define FSPS_SEG_ALL       2'h0
`define FSPS_SEG_HALF      2'h1
`define FSPS_SEG_LOW       2'h2
`define FSPS_SEG_NONE      2'h3
`define FSPS_LIMIT_HALF    15'h4000
`define FSPS_LIMIT_LOW     15'h0200

// Timing: clock period and the typical erase/program time
`define FSPS_CLK_NS        100
`define FSPS_ERASE_US      2000
`define FSPS_PROG_US       2000
`define FSPS_ERASE_CYC     ((`FSPS_ERASE_US * 1000) / `FSPS_CLK_NS)
`define FSPS_PROG_CYC      ((`FSPS_PROG_US * 1000) / `FSPS_CLK_NS)

`endif

/* rtl/fsps_latch_bank.v */
// Write-latch block: one word per latch, loaded one at a time.
// Assumes the sequencer gives it the index; same clock as the sequencer.
`include "fsps_consts.vh"

module fsps_latch_bank #(
  parameter WORD_W = `FSPS_WORD_W,
  parameter DEPTH  = `FSPS_ROW_WORDS,
  parameter IDX_W  = 5
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              reset,
  // Load side
  input  wire              load,
  input  wire [IDX_W-1:0]  load_idx,
  input  wire [WORD_W-1:0] load_data,
  input  wire              wipe,
  // Read side
  input  wire [IDX_W-1:0]  rd_idx,
  output wire [WORD_W-1:0] rd_data
);

  reg [WORD_W-1:0] latch_r [0:DEPTH-1];
  integer i;

  // Not reachable by software except through the sequencer
  always @(posedge core_clk) begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (reset || wipe) begin
        latch_r[i] <= `FSPS_ERASED_WORD;
      end else if (load && (load_idx == i[IDX_W-1:0])) begin
        latch_r[i] <= load_data;
      end
    end
  end

  assign rd_data = latch_r[rd_idx];

endmodule // fsps_latch_bank

/* verif/fsps_seq_asserts.sv */
// Port checker for the flash self-program sequencer.
// Assumes it is bound onto fsps_seq; one clock, synchronous reset.
module fsps_seq_asserts #(
  parameter ERASE_CYCLES = 20000,
  parameter PROG_CYCLES  = 20000
) (
  // Clock, reset, configuration
  input wire        core_clk,
  input wire        reset,
  input wire [1:0]  protect_segment_field,
  // Core and flash side
  input wire        cpu_stall_r,
  input wire        cpu_squash_r,
  input wire [14:0] fl_addr_r,
  input wire        fl_rd_en_r,
  input wire        fl_wr_en_r,
  input wire        fl_erase_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  reg  [15:0] stall_len_r;
  reg  [5:0]  wr_cnt_r;
  wire        prot_ok = (protect_segment_field == 2'h3) ||
                        (protect_segment_field == 2'h2 && fl_addr_r >= 15'h0200) ||
                        (protect_segment_field == 2'h1 && fl_addr_r >= 15'h4000);
  always @(posedge core_clk) begin
    if (reset || !cpu_stall_r)
      stall_len_r <= 16'h0000;
    else
      stall_len_r <= stall_len_r + 16'h0001;
    if (reset || $rose(cpu_stall_r))
      wr_cnt_r <= 6'h00;
    else if (fl_wr_en_r)
      wr_cnt_r <= wr_cnt_r + 6'h01;
  end
  squash_pulse_a: assert property (cpu_squash_r |=> !cpu_squash_r)
    else $error("squash longer than one cycle");
  read_squash_a: assert property (fl_rd_en_r |-> cpu_squash_r && !cpu_stall_r)
    else $error("flash read without squash or under stall");
  erase_row_a: assert property (fl_erase_r |-> fl_addr_r[4:0] == 5'h00 && cpu_stall_r)
    else $error("erase not on row base or not stalled");
  stall_lead_a: assert property ($rose(cpu_stall_r) |=> fl_erase_r || fl_wr_en_r)
    else $error("stall without flash operation");
  prog_stall_a: assert property (fl_wr_en_r |-> cpu_stall_r && !fl_erase_r)
    else $error("program pulse outside stall or with erase");
  burst_base_a: assert property ($rose(fl_wr_en_r) |-> fl_addr_r[4:0] == 5'h00)
    else $error("program burst not block aligned");
  burst_step_a: assert property (fl_wr_en_r && $past(fl_wr_en_r) |->
    fl_addr_r == $past(fl_addr_r) + 15'h0001 && fl_addr_r[4:0] != 5'h00)
    else $error("program burst stepped wrongly");
  burst_full_a: assert property ($fell(cpu_stall_r) |-> wr_cnt_r == 6'h00 ||
    wr_cnt_r == 6'h20)
    else $error("program burst not whole block");
  guard_seg_a: assert property (fl_erase_r || fl_wr_en_r |-> prot_ok)
    else $error("write into protected segment");
  // A stall cut short by reset is not a finished operation
  stall_len_a: assert property ($fell(cpu_stall_r) && !$past(reset) |->
    stall_len_r >= ERASE_CYCLES ||
    stall_len_r >= PROG_CYCLES)
    else $error("stall shorter than operation time");
  stall_bound_a: assert property (cpu_stall_r |->
    stall_len_r < ERASE_CYCLES + PROG_CYCLES + 40)
    else $error("stall never ends");
  cover property (fl_erase_r);
  cover property (fl_rd_en_r);
  cover property ($fell(cpu_stall_r) && wr_cnt_r == 6'h20);
endmodule // fsps_seq_asserts

bind fsps_seq fsps_seq_asserts #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)
) u_chk (
  .core_clk(core_clk),
  .reset(reset),
  .protect_segment_field(protect_segment_field),
  .cpu_stall_r(cpu_stall_r),
  .cpu_squash_r(cpu_squash_r),
  .fl_addr_r(fl_addr_r),
  .fl_rd_en_r(fl_rd_en_r),
  .fl_wr_en_r(fl_wr_en_r),
  .fl_erase_r(fl_erase_r)
);

/* verif/fsps_flash_model.sv */
// Flash macro model: synchronous read, row erase, program clears bits only.
// Assumes one-cycle strobes from the sequencer on the same clock.
module fsps_flash_model (
  // Clock
  input  wire         core_clk,
  // Macro port
  input  wire  [14:0] fl_addr,
  input  wire  [13:0] fl_wdata,
  input  wire         fl_rd_en,
  input  wire         fl_wr_en,
  input  wire         fl_erase,
  output logic [13:0] fl_rdata
);
  logic [13:0] mem [0:32767];
  initial begin
    for (int i = 0; i < 32768; i++)
      mem[i] = 14'(i * 7) ^ 14'h2A5A;
    fl_rdata = 14'h0000;
  end
  always @(posedge core_clk) begin
    if (fl_rd_en)
      fl_rdata <= mem[fl_addr];
    else
      fl_rdata <= ~fl_rdata; // Released bus: a late sample must not look valid
    if (fl_erase)
      for (int i = 0; i < 32; i++)
        mem[{fl_addr[14:5], 5'(i)}] <= 14'h3FFF;
    if (fl_wr_en)
      mem[fl_addr] <= mem[fl_addr] & fl_wdata;
  end
endmodule // fsps_flash_model

/* verif/tb_flash_self_program_sequencer.sv */
// Bench for the sequencer: software flows driven through the register port.
// Assumes the flash model on the macro side; the bench plays the core.
module tb_flash_self_program_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [1:0]  seg = 2'h3;
  logic        guard = 1'b0;
  wire  [7:0]  rdata;
  wire         stall, squash, rd_en, wr_en, erase;
  wire  [14:0] fl_addr;
  wire  [13:0] fl_wdata, fl_rdata;
  logic [13:0] exp_mem [0:32767];
  logic [13:0] latch [0:31];
  logic [31:0] rng = 32'h01D7;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n_stall = 0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
    if ($rose(stall))
      n_stall <= n_stall + 1;
  fsps_seq #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) dut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata),
    .protect_segment_field(seg), .code_guard_bit(guard),
    .cpu_stall_r(stall), .cpu_squash_r(squash), .fl_addr_r(fl_addr),
    .fl_wdata_r(fl_wdata), .fl_rd_en_r(rd_en), .fl_wr_en_r(wr_en),
    .fl_erase_r(erase), .fl_rdata(fl_rdata));
  fsps_flash_model u_flash (
    .core_clk(core_clk), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_rd_en(rd_en), .fl_wr_en(wr_en), .fl_erase(erase), .fl_rdata(fl_rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic locked(input logic [14:0] a, input logic [1:0] s);
    return s == 2'h0 || (s == 2'h1 && a < 15'h4000) || (s == 2'h2 && a < 15'h0200);
  endfunction
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge core_clk);
  endtask
  task automatic set_ad(input logic [14:0] a, input logic [13:0] d);
    wr(3'h0, a[7:0]);
    wr(3'h1, {1'b0, a[14:8]});
    wr(3'h2, d[7:0]);
    wr(3'h3, {2'b00, d[13:8]});
  endtask
  task automatic unlock(input logic [7:0] c);
    wr(3'h4, c);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'hAA);
    wr(3'h4, c | 8'h02);
  endtask
  task automatic go(input logic [7:0] c, output logic [7:0] v);
    int k;
    unlock(c);
    k = 0;
    v = 8'h02;
    while (v[1] && k < 200) begin
      rd(3'h4, v);
      k++;
    end
    chk(14'(v & 8'h02), 14'h0000);
  endtask
  task automatic rchk(input logic [14:0] a);
    logic [7:0] lo, hi;
    set_ad(a, 14'h0000);
    wr(3'h4, 8'h81);
    repeat (3) @(posedge core_clk);
    rd(3'h2, lo);
    rd(3'h3, hi);
    chk({hi[5:0], lo}, exp_mem[a]);
  endtask
  task automatic erase_row(input logic [14:0] a);
    logic [7:0] v;
    set_ad(a, 14'h0000);
    go(8'h94, v);
    if (!locked(a, seg)) begin
      chk(14'(v & 8'h10), 14'h0000);
      for (int i = 0; i < 32; i++)
        exp_mem[{a[14:5], 5'(i)}] = 14'h3FFF;
    end
  endtask
  task automatic load(input logic [14:0] a, input logic [13:0] d, input logic lo);
    logic [7:0] v;
    int s;
    s = n_stall;
    set_ad(a, d);
    go(lo ? 8'hA4 : 8'h84, v);
    if (!locked(a, seg))
      latch[a[4:0]] = d;
    if (!lo && !locked(a, seg))
      for (int i = 0; i < 32; i++) begin
        exp_mem[{a[14:5], 5'(i)}] &= latch[i];
        latch[i] = 14'h3FFF;
      end
    chk(14'(n_stall - s), (lo || locked(a, seg)) ? 14'h0000 : 14'h0001);
  endtask
  initial begin
    logic [7:0] v;
    logic [14:0] a;
    for (int i = 0; i < 32768; i++)
      exp_mem[i] = 14'(i * 7) ^ 14'h2A5A;
    for (int i = 0; i < 32; i++)
      latch[i] = 14'h3FFF;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    // Aborted flag has no power-on value; software clears it first
    wr(3'h4, 8'h00);
    for (int i = 4; i < 8; i++) begin
      rd(3'(i), v);
      chk({6'h00, v}, 14'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      a = rng[14:0];
      guard <= rng[31];
      rchk(a);
    end
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h11);
    rd(3'h2, v);
    chk({6'h00, v}, {6'h00, exp_mem[a][7:0]});
    // Read with config space selected leaves the data pair alone
    wr(3'h4, 8'hC1);
    repeat (3) @(posedge core_clk);
    rd(3'h2, v);
    chk({6'h00, v}, {6'h00, exp_mem[a][7:0]});
    for (int s = 0; s < 4; s++) begin
      seg <= 2'(s);
      rng = xs(rng);
      a = rng[14:0] & (s == 2 ? 15'h01FF : (s == 1 ? 15'h3FFF : 15'h7FFF));
      erase_row(a);
      rchk(a);
      rchk({a[14:5], 5'h1F});
    end
    rng = xs(rng);
    a = {rng[14:5], 5'h00};
    erase_row(a);
    for (int i = 0; i < 32; i++) begin
      rng = xs(rng);
      if (i != 7)
        load(a | 15'(i), rng[13:0], i != 31);
    end
    for (int i = 0; i < 32; i++)
      rchk(a | 15'(i));
    load(a | 15'h0003, 14'h0F0F, 1'b0);
    rchk(a | 15'h0003);
    // Fresh row, so a stale latch would show up as old data
    erase_row(a);
    load(a | 15'h0003, 14'h0F0F, 1'b0);
    rchk(a | 15'h0004);
    for (int f = 0; f < 3; f++) begin
      set_ad(a, 14'h0000);
      wr(3'h4, f == 2 ? 8'h90 : 8'h94);
      wr(3'h5, 8'h55);
      wr(f == 0 ? 3'h0 : 3'h5, f == 0 ? a[7:0] : (f == 1 ? 8'h5A : 8'hAA));
      wr(3'h4, 8'h96);
      rd(3'h4, v);
      chk(14'(v & 8'h02), 14'h0000);
      rchk(a | 15'h0003);
    end
    set_ad(a, 14'h0000);
    unlock(8'h94);
    repeat (4) @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(3'h4, v);
    chk({6'h00, v}, 14'h0008);
    test_done();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
endmodule // tb_flash_self_program_sequencer
